//--- common/crc_defs.vh
`ifndef CRC_DEFS_VH
`define CRC_DEFS_VH

// register byte offsets
`define OFS_DATA 4'h0
`define OFS_POLY 4'h4
`define OFS_CTRL 4'h8

// control field positions
`define CTRL_WTR_HI 31
`define CTRL_WTR_LO 30
`define CTRL_RTR_HI 29
`define CTRL_RTR_LO 28
`define CTRL_RSVD 27
`define CTRL_CMPL 26
`define CTRL_SEED 25
`define CTRL_WIDTH 24

// reset values
`define RST_DATA 32'hFFFFFFFF
`define RST_POLY 32'h00001021
`define RST_CTRL 32'h00000000

// transpose codes
`define TR_NONE 2'h0
`define TR_BITS 2'h1
`define TR_BOTH 2'h2
`define TR_BYTES 2'h3

`endif

//--- hw/crc_byte_step.v
`timescale 1ns/10ps
// one byte shifted through the crc register, msb first
module crc_byte_step (
    // state in
    input wire [31:0] crc_in,
    input wire [31:0] poly,
    input wire [7:0] data_byte,
    input wire width32,
    // state out
    output reg [31:0] crc_out
);
    integer i;
    reg fb;
    always @* begin
        crc_out = crc_in;
        fb = 1'b0;
        for (i = 7; i >= 0; i = i - 1) begin
            fb = (width32 ? crc_out[31] : crc_out[15]) ^ data_byte[i];
            crc_out = {crc_out[30:0], 1'b0};
            if (fb) begin
                crc_out = crc_out ^ poly;
            end
        end
        if (!width32) begin
            crc_out = {16'h0000, crc_out[15:0]};
        end
    end
endmodule

//--- hw/crc_config_registers.v
`timescale 1ns/10ps
`include "crc_defs.vh"
// Overview of operation
// - the upper polynomial half acts as coefficients only in 32-bit width.
// - writes to the upper polynomial half are ignored in 16-bit width.
// - the lower polynomial half is read/write and always used.
// - control bits 31:30 transpose written data: none, bits, bits and bytes, bytes.
// - control bits 29:28 transpose data register reads with the same codes.
// - control bit 26 complements every data register read.
// - control bit 25 makes data writes load the seed instead of feeding the crc.
// - control bit 24 selects 16-bit (0) or 32-bit (1) width.
// - control bit 27 and bits 23:0 read as zero.
// - the polynomial resets to 0x00001021.
// - the control register resets to zero.
// - in 16-bit width the seed and result use the lower data half only.
module crc_config_registers (
    // clock and reset
    input wire clk,
    input wire rst,
    // register access
    input wire [3:0] addr,
    input wire wr_en,
    input wire rd_en,
    input wire [3:0] byte_en,
    input wire [31:0] wr_data,
    output reg [31:0] rd_data,
    // configuration to the crc core
    output wire width_sel,
    output wire seed_write_sel,
    output wire read_complement_en,
    output wire [1:0] write_transpose_sel,
    output wire [1:0] read_transpose_sel
);
    localparam LANES = 4;
    reg [31:0] data_q;
    reg [31:0] data_d;
    reg [31:0] polynomial_reg_q;
    reg [31:0] polynomial_reg_d;
    reg [31:0] ctrl_q;
    reg [31:0] ctrl_d;
    reg [31:0] rd_data_d;
    wire [31:0] lane_mask;
    wire [3:0] swap_en;
    wire byte_swap;
    wire [3:0] tr_en;
    wire [31:0] wr_tr;
    wire [31:0] seed_val;
    wire [31:0] poly_eff;
    wire [32 * (LANES + 1) - 1:0] chain;
    wire [32 * LANES - 1:0] step_out;
    wire [31:0] cmpl_mask;
    wire [31:0] data_view;
    wire [31:0] rd_view;
    wire [31:0] rd_tr;
    wire data_wr;
    wire poly_wr;
    wire ctrl_wr;
    genvar g;

    function [31:0] bitrev_bytes;
        input [31:0] v;
        integer k;
        begin
            bitrev_bytes = 32'h00000000;
            for (k = 0; k < 8; k = k + 1) begin
                bitrev_bytes[24 + k] = v[31 - k];
                bitrev_bytes[16 + k] = v[23 - k];
                bitrev_bytes[8 + k] = v[15 - k];
                bitrev_bytes[k] = v[7 - k];
            end
        end
    endfunction

    function [31:0] transpose;
        input [31:0] v;
        input [1:0] sel;
        begin
            case (sel)
                `TR_NONE: transpose = v;
                `TR_BITS: transpose = bitrev_bytes(v);
                `TR_BOTH: transpose = bitrev_bytes({v[7:0], v[15:8], v[23:16], v[31:24]});
                `TR_BYTES: transpose = {v[7:0], v[15:8], v[23:16], v[31:24]};
                default: transpose = v;
            endcase
        end
    endfunction

    // keeps the lower half only while the width is 16 bits
    function [31:0] fit_width;
        input [31:0] v;
        input wide;
        begin
            fit_width = wide ? v : {16'h0000, v[15:0]};
        end
    endfunction

    // write strobe aimed at one register offset
    function hit;
        input en;
        input [3:0] a;
        input [3:0] ofs;
        begin
            hit = en && (a == ofs);
        end
    endfunction

    assign write_transpose_sel = ctrl_q[`CTRL_WTR_HI:`CTRL_WTR_LO];
    assign read_transpose_sel = ctrl_q[`CTRL_RTR_HI:`CTRL_RTR_LO];
    assign read_complement_en = ctrl_q[`CTRL_CMPL];
    assign seed_write_sel = ctrl_q[`CTRL_SEED];
    assign width_sel = ctrl_q[`CTRL_WIDTH];

    assign data_wr = hit(wr_en, addr, `OFS_DATA);
    assign poly_wr = hit(wr_en, addr, `OFS_POLY);
    assign ctrl_wr = hit(wr_en, addr, `OFS_CTRL);

    // unused byte lanes are zero before transposing; a byte swap mirrors the valid lanes
    generate
        for (g = 0; g < LANES; g = g + 1) begin : lane_map
            assign lane_mask[8 * g +: 8] = {8{byte_en[g]}};
            assign swap_en[g] = byte_en[LANES - 1 - g];
        end
    endgenerate
    assign byte_swap = (write_transpose_sel == `TR_BOTH) || (write_transpose_sel == `TR_BYTES);
    assign tr_en = byte_swap ? swap_en : byte_en;
    assign wr_tr = transpose(wr_data & lane_mask, write_transpose_sel);
    assign seed_val = fit_width(wr_tr, width_sel);
    assign poly_eff = fit_width(polynomial_reg_q, width_sel);

    // bytes fed msb lane first, only the valid lanes advance the crc
    assign chain[32 * LANES +: 32] = data_q;
    generate
        for (g = 0; g < LANES; g = g + 1) begin : lane
            crc_byte_step u_step (
                .crc_in(chain[32 * (g + 1) +: 32]),
                .poly(poly_eff),
                .data_byte(wr_tr[8 * g +: 8]),
                .width32(width_sel),
                .crc_out(step_out[32 * g +: 32])
            );
            assign chain[32 * g +: 32] = tr_en[g] ? step_out[32 * g +: 32] : chain[32 * (g + 1) +: 32];
        end
    endgenerate

    always @* begin
        data_d = data_q;
        if (data_wr) begin
            if (seed_write_sel) begin
                data_d = seed_val;
            end else begin
                data_d = chain[31:0];
            end
        end
    end

    // the upper half holds its value while the width is 16 bits
    always @* begin
        polynomial_reg_d = polynomial_reg_q;
        if (poly_wr) begin
            if (byte_en[0]) begin
                polynomial_reg_d[7:0] = wr_data[7:0];
            end
            if (byte_en[1]) begin
                polynomial_reg_d[15:8] = wr_data[15:8];
            end
            if (width_sel && byte_en[2]) begin
                polynomial_reg_d[23:16] = wr_data[23:16];
            end
            if (width_sel && byte_en[3]) begin
                polynomial_reg_d[31:24] = wr_data[31:24];
            end
        end
    end

    // only the top byte holds fields; the rest of the word stays zero
    always @* begin
        ctrl_d = ctrl_q;
        if (ctrl_wr && byte_en[3]) begin
            ctrl_d[31:24] = wr_data[31:24];
            ctrl_d[`CTRL_RSVD] = 1'b0;
        end
        ctrl_d[23:0] = 24'h000000;
    end

    always @(posedge clk) begin
        if (rst) begin
            data_q <= `RST_DATA;
            polynomial_reg_q <= `RST_POLY;
            ctrl_q <= `RST_CTRL;
        end else begin
            data_q <= data_d;
            polynomial_reg_q <= polynomial_reg_d;
            ctrl_q <= ctrl_d;
        end
    end

    // complement first, so a lane-moving read transpose still flips the stored bits
    assign data_view = fit_width(data_q, width_sel);
    assign cmpl_mask = fit_width(32'hFFFFFFFF, width_sel);
    assign rd_view = read_complement_en ? (data_view ^ cmpl_mask) : data_view;
    assign rd_tr = transpose(rd_view, read_transpose_sel);

    // read word for the addressed register, unmapped offsets give zero
    always @* begin
        case (addr)
            `OFS_DATA: rd_data_d = rd_tr;
            `OFS_POLY: rd_data_d = polynomial_reg_q;
            `OFS_CTRL: rd_data_d = ctrl_q;
            default: rd_data_d = 32'h00000000;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            rd_data <= 32'h00000000;
        end else if (rd_en) begin
            rd_data <= rd_data_d;
        end
    end
endmodule

//--- sim/crc_config_properties.sv
`timescale 1ns/10ps
module crc_config_checker (
    // bus side
    input wire clk,
    input wire rst,
    input wire [3:0] addr,
    input wire wr_en,
    input wire rd_en,
    input wire [3:0] byte_en,
    input wire [31:0] wr_data,
    input wire [31:0] rd_data,
    // configuration
    input wire width_sel,
    input wire seed_write_sel,
    input wire read_complement_en,
    input wire [1:0] write_transpose_sel,
    input wire [1:0] read_transpose_sel
);
    wire cw = wr_en && addr == 4'h8 && byte_en[3];
    wire dr = rd_en && addr == 4'h0 && read_transpose_sel == 2'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_wtr; cw |=> write_transpose_sel == $past(wr_data[31:30]); endproperty
    a_wtr: assert property (p_wtr) else $error("wtr");
    property p_rtr; cw |=> read_transpose_sel == $past(wr_data[29:28]); endproperty
    a_rtr: assert property (p_rtr) else $error("rtr");
    property p_cmp; cw |=> read_complement_en == $past(wr_data[26]); endproperty
    a_cmp: assert property (p_cmp) else $error("cmp");
    property p_seed; cw |=> seed_write_sel == $past(wr_data[25]); endproperty
    a_seed: assert property (p_seed) else $error("seed");
    property p_wid; cw |=> width_sel == $past(wr_data[24]); endproperty
    a_wid: assert property (p_wid) else $error("wid");
    property p_rsv; rd_en && addr == 4'h8 |=> !rd_data[27] && rd_data[23:0] == 24'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("rsv");
    property p_rst; $fell(rst) |-> {width_sel, seed_write_sel, read_complement_en} == 3'h0; endproperty
    a_rst: assert property (p_rst) else $error("rst");
    property p_h16; dr && !width_sel |=> rd_data[31:16] == 16'h0; endproperty
    a_h16: assert property (p_h16) else $error("h16");
    c_ctrl: cover property (cw ##2 (rd_en && addr == 4'h8));
    c_cmp: cover property (dr && read_complement_en);
    c_seed: cover property (seed_write_sel && wr_en && addr == 4'h0);
endmodule
bind crc_config_registers crc_config_checker chk_i (.clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .byte_en(byte_en), .wr_data(wr_data), .rd_data(rd_data), .width_sel(width_sel),
    .seed_write_sel(seed_write_sel), .read_complement_en(read_complement_en),
    .write_transpose_sel(write_transpose_sel), .read_transpose_sel(read_transpose_sel));

//--- sim/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic clk = 0, rst = 1, wr_en = 0, rd_en = 0;
    logic [3:0] addr = 4'h0, byte_en = 4'hF;
    logic [31:0] wr_data = 32'h0, rd_data, c;
    logic width_sel, seed_write_sel, read_complement_en;
    logic [1:0] write_transpose_sel, read_transpose_sel;
    int fails = 0, comparisons = 0, cyc = 0;
    always #10 clk = ~clk;
    crc_config_registers uut (.clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
        .byte_en(byte_en), .wr_data(wr_data), .rd_data(rd_data), .width_sel(width_sel),
        .seed_write_sel(seed_write_sel), .read_complement_en(read_complement_en),
        .write_transpose_sel(write_transpose_sel), .read_transpose_sel(read_transpose_sel));
    function [31:0] tp(input [31:0] v, input [1:0] s);
        int i;
        for (i = 0; i < 32; i++) begin
            tp[i] = s == 0 ? v[i] : s == 1 ? v[(i & ~7) + 7 - (i & 7)] :
                    s == 2 ? v[31 - i] : v[24 - (i & ~7) + (i & 7)];
        end
    endfunction
    // msb first shift of the low n bits of d
    function [31:0] cr(input [31:0] r, d, p, input w, input int n);
        int k;
        for (k = n - 1; k >= 0; k--) begin
            r = ((w ? r[31] : r[15]) ^ d[k]) ? (r << 1) ^ p : r << 1;
        end
        cr = w ? r : {16'h0, r[15:0]};
    endfunction
    task report_and_stop;
        $display("fails %0d comparisons %0d", fails, comparisons);
        if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task wr_be(input [3:0] a, input [3:0] be, input [31:0] d);
        @(negedge clk);
        addr = a;
        byte_en = be;
        wr_data = d;
        wr_en = 1;
        @(negedge clk);
        wr_en = 0;
        byte_en = 4'hF;
    endtask
    task wr(input [3:0] a, input [31:0] d);
        wr_be(a, 4'hF, d);
    endtask
    task rd(input [3:0] a, input [31:0] e, input string n);
        @(negedge clk);
        addr = a;
        rd_en = 1;
        @(negedge clk);
        rd_en = 0;
        chk(n, e, rd_data);
    endtask
    task t_reset;
        rd(4'h4, 32'h00001021, "poly");
        rd(4'h8, 32'h0, "ctrl");
        rd(4'h0, 32'h0000FFFF, "data");
    endtask
    task t_ctrl;
        wr(4'h8, 32'hFFFFFFFF);
        rd(4'h8, 32'hF7000000, "ctrl");
        c = {25'h0, width_sel, seed_write_sel, read_complement_en, write_transpose_sel, read_transpose_sel};
        chk("cfg", 32'h7F, c);
    endtask
    task t_crc16;
        wr(4'h8, 32'h02000000);
        wr(4'h0, 32'h1234FFFF);
        wr(4'h8, 32'h0);
        wr(4'h0, 32'hA5C30F1E);
        rd(4'h0, cr(32'hFFFF, 32'hA5C30F1E, 32'h1021, 0, 32), "crc16");
        wr(4'h8, 32'h04000000);
        rd(4'h0, cr(32'hFFFF, 32'hA5C30F1E, 32'h1021, 0, 32) ^ 32'hFFFF, "cmp16");
    endtask
    task t_poly;
        wr(4'h4, 32'h04C11DB7);
        rd(4'h4, 32'h00001DB7, "poly16");
        wr(4'h8, 32'h01000000);
        wr(4'h4, 32'h04C11DB7);
        rd(4'h4, 32'h04C11DB7, "poly32");
    endtask
    task t_crc32;
        int s;
        for (s = 0; s < 4; s++) begin
            wr(4'h8, {s[1:0], 6'h3, 24'h0});
            wr(4'h0, 32'hFFFFFFFF);
            wr(4'h8, {s[1:0], 6'h1, 24'h0});
            wr(4'h0, 32'h1234ABCD);
            c = cr(32'hFFFFFFFF, tp(32'h1234ABCD, s[1:0]), 32'h04C11DB7, 1, 32);
            rd(4'h0, c, "crc32");
        end
        for (s = 0; s < 4; s++) begin
            wr(4'h8, {2'h0, s[1:0], 4'h5, 24'h0});
            rd(4'h0, ~tp(c, s[1:0]), "rtr");
        end
    endtask
    task t_lanes;
        wr_be(4'h8, 4'h7, 32'h01000000);
        rd(4'h8, 32'h35000000, "ctrl_lane");
        wr(4'h8, 32'h02000000);
        wr(4'h0, 32'h0000FFFF);
        wr(4'h8, 32'h0);
        wr_be(4'h0, 4'h3, 32'hEEEE1234);
        c = cr(32'hFFFF, 32'h1234, 32'h1DB7, 0, 16);
        rd(4'h0, c, "lane16");
        wr(4'h8, 32'h34000000);
        rd(4'h0, tp(c ^ 32'hFFFF, 2'h3), "swap16");
        wr(4'h8, 32'h0);
        wr_be(4'h4, 4'hC, 32'hFFFF0000);
        rd(4'h4, 32'h04C11DB7, "poly_hi16");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            report_and_stop;
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        rst = 0;
        t_reset;
        t_ctrl;
        t_crc16;
        t_poly;
        t_crc32;
        t_lanes;
        report_and_stop;
    end
endmodule
